// File: rtl/srr_pkg.sv
// package for the soft and user reset controller: constants, types and behaviour notes
// Notes on behaviour
// - a write with any command bit set starts a soft reset; bits combine freely
// - a soft reset ends on the third slow tick after its start (two to three slow periods), later while the pin is driven or low
// - selected internal resets assert as soon as the write is seen
// - soft-commanded internal resets release on the third slow tick, which ends the soft reset unless the pin is still driven or low
// - external command drives reset pin low for the length field; no user reset
// - cause field shows soft reset only when processor reset bit was set
// - in-progress flag sets at command detection and clears at soft reset end
// - while in-progress flag is set, control writes are ignored
// - user reset entered from idle when pin sampled low and user reset enable is 1
// - reset pin input is resynchronised on the slow clock before use
// - user reset asserts processor and peripheral resets at once
// - after pin rises, two-cycle resync then three-cycle startup end user reset
// - processor clock re-enabled once synchronised pin is confirmed high
// - cause field loaded with 0x4 when processor reset releases after user reset
package srr_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLOW_PERIOD_NS = 30518;
   localparam int SLOW_DIV_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [1:0] SOFT_TICKS = 2'h3;
   localparam logic [1:0] STARTUP_TICKS = 2'h3;
   localparam logic [2:0] CAUSE_RESET = 3'h0;
   localparam logic [2:0] CAUSE_SOFT = 3'h3;
   localparam logic [2:0] CAUSE_USER = 3'h4;
   localparam int ERST_LEN_W = 4;

   // command bits of one control write
   typedef struct packed {
      logic external_pin_reset_cmd;
      logic peripheral_reset_cmd;
      logic processor_reset_cmd;
   } srr_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SOFT = 4'b0010,
      ST_USER_LOW = 4'b0100,
      ST_USER_WAIT = 4'b1000
   } srr_state_t;
endpackage

// File: rtl/srr_ctrl.sv
// soft and user reset sequencer with slow clock enable and pin resynchroniser
`timescale 1ns/1ns
module srr_ctrl
   import srr_pkg::*;
#(
   parameter int SLOW_DIV = SLOW_DIV_CYCLES
)
(
   input wire logic clk, // master clock
   input wire logic rst, // async reset, active high
   input wire logic ctrl_wr, // control register write strobe
   input wire srr_cmd_t ctrl_cmd, // command bits of that write
   input wire logic user_reset_enable, // mode bit: pin low starts user reset
   input wire logic [ERST_LEN_W-1:0] external_reset_length, // pin pulse length
   input wire logic nrst_pin_in, // reset pin level, asynchronous
   output logic nrst_pin_out, // reset pin drive value, always low
   output logic nrst_pin_oe, // high while pulling the pin low
   output logic proc_reset, // processor reset, active high
   output logic periph_reset, // peripheral reset, active high
   output logic proc_clk_en, // processor clock enable
   output logic soft_reset_in_progress, // soft reset busy flag
   output logic [2:0] reset_cause_field // last reset cause
);
   logic [15:0] div_reg, div_next;
   logic tick_reg, tick_next;
   logic pin_meta_reg, pin_sync_reg, pin_s1_reg, pin_s2_reg;
   srr_state_t state_reg, state_next;
   logic [1:0] cnt_reg, cnt_next;
   logic [ERST_LEN_W:0] ext_cnt_reg, ext_cnt_next;
   logic proc_reg, proc_next, periph_reg, periph_next, clk_en_reg, clk_en_next;
   logic busy_reg, busy_next, oe_reg, oe_next;
   logic [2:0] cause_reg, cause_next;

   // slow clock enable divider
   always_comb
   begin
      div_next = div_reg + 16'h0001;
      tick_next = 1'b0;
      if (div_reg == 16'(SLOW_DIV - 1))
      begin
         div_next = 16'h0000;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
         tick_reg <= tick_next;
      end
   end

   // pin crosses into clk, then two slow-tick stages
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
      end
      else
      begin
         pin_meta_reg <= nrst_pin_in;
         pin_sync_reg <= pin_meta_reg;
         if (tick_reg)
         begin
            pin_s1_reg <= pin_sync_reg;
            pin_s2_reg <= pin_s1_reg;
         end
      end
   end

   // sequencer next state
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      ext_cnt_next = ext_cnt_reg;
      proc_next = proc_reg;
      periph_next = periph_reg;
      clk_en_next = clk_en_reg;
      busy_next = busy_reg;
      oe_next = oe_reg;
      cause_next = cause_reg;
      unique case (state_reg)
         ST_IDLE:
         begin
            if (user_reset_enable && !pin_s1_reg)
            begin
               state_next = ST_USER_LOW;
               proc_next = 1'b1;
               periph_next = 1'b1;
               clk_en_next = 1'b0;
            end
            else if (ctrl_wr && (ctrl_cmd != '0))
            begin
               state_next = ST_SOFT;
               cnt_next = 2'h0;
               ext_cnt_next = {1'b0, external_reset_length} + 5'h01;
               busy_next = 1'b1;
               proc_next = ctrl_cmd.processor_reset_cmd;
               periph_next = ctrl_cmd.peripheral_reset_cmd;
               oe_next = ctrl_cmd.external_pin_reset_cmd;
               if (ctrl_cmd.processor_reset_cmd)
               begin
                  cause_next = CAUSE_SOFT;
               end
            end
         end
         ST_SOFT:
         begin
            // writes are ignored and pin lows only delay the end here: our own pulse is not a user reset
            if (tick_reg)
            begin
               if (cnt_reg != SOFT_TICKS)
               begin
                  cnt_next = cnt_reg + 2'h1;
               end
               if (oe_reg)
               begin
                  ext_cnt_next = ext_cnt_reg - 5'h01;
                  if (ext_cnt_reg == 5'h01)
                  begin
                     oe_next = 1'b0;
                  end
               end
               if (cnt_reg == SOFT_TICKS - 2'h1)
               begin
                  proc_next = 1'b0;
                  periph_next = 1'b0;
               end
               if ((cnt_reg >= SOFT_TICKS - 2'h1) && !oe_next && pin_s1_reg && pin_s2_reg)
               begin
                  state_next = ST_IDLE;
                  busy_next = 1'b0;
               end
            end
         end
         ST_USER_LOW:
         begin
            // s2 takes a high level on this tick, so the pin has passed both stages high;
            // testing s2 here instead would let a stale high end the reset while pin is low
            if (tick_reg && pin_s1_reg)
            begin
               state_next = ST_USER_WAIT;
               clk_en_next = 1'b1;
               cnt_next = 2'h0;
            end
         end
         ST_USER_WAIT:
         begin
            if (tick_reg)
            begin
               cnt_next = cnt_reg + 2'h1;
               if (cnt_reg == STARTUP_TICKS - 2'h1)
               begin
                  state_next = ST_IDLE;
                  proc_next = 1'b0;
                  periph_next = 1'b0;
                  cause_next = CAUSE_USER;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 2'h0;
         ext_cnt_reg <= '0;
         proc_reg <= 1'b0;
         periph_reg <= 1'b0;
         clk_en_reg <= 1'b1;
         busy_reg <= 1'b0;
         oe_reg <= 1'b0;
         cause_reg <= CAUSE_RESET;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ext_cnt_reg <= ext_cnt_next;
         proc_reg <= proc_next;
         periph_reg <= periph_next;
         clk_en_reg <= clk_en_next;
         busy_reg <= busy_next;
         oe_reg <= oe_next;
         cause_reg <= cause_next;
      end
   end

   // outputs straight from flops; pin drive value is a constant low
   assign nrst_pin_out = 1'b0;
   assign nrst_pin_oe = oe_reg;
   assign proc_reset = proc_reg;
   assign periph_reset = periph_reg;
   assign proc_clk_en = clk_en_reg;
   assign soft_reset_in_progress = busy_reg;
   assign reset_cause_field = cause_reg;

   // helper: slow ticks seen while a soft reset is busy
   logic [3:0] soft_ticks_seen;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         soft_ticks_seen <= 4'h0;
      end
      else
      begin
         // saturates so that a long pin pulse cannot wrap the count
         soft_ticks_seen <= busy_reg ?
            soft_ticks_seen + 4'(tick_reg && (soft_ticks_seen != 4'hf)) : 4'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   wr_start_a: assert property (state_reg == ST_IDLE && pin_s1_reg && ctrl_wr
      && ctrl_cmd != '0 |=> soft_reset_in_progress) else $error("soft reset not started");
   busy_ignore_a: assert property (busy_reg && ctrl_wr && !tick_reg
      |=> $stable(proc_reset) && $stable(periph_reset) && $stable(reset_cause_field))
      else $error("write honoured while busy");
   zero_cmd_a: assert property (state_reg == ST_IDLE && pin_s1_reg && ctrl_wr
      && ctrl_cmd == '0 |=> !soft_reset_in_progress && !proc_reset && !periph_reset)
      else $error("empty command had an effect");
   proc_now_a: assert property (state_reg == ST_IDLE && pin_s1_reg && ctrl_wr
      && ctrl_cmd.processor_reset_cmd |=> proc_reset && reset_cause_field == CAUSE_SOFT)
      else $error("processor reset late");
   cause_keep_a: assert property (state_reg == ST_IDLE && pin_s1_reg && ctrl_wr
      && ctrl_cmd != '0 && !ctrl_cmd.processor_reset_cmd |=> $stable(reset_cause_field))
      else $error("cause changed without processor bit");
   ext_drive_a: assert property (state_reg == ST_IDLE && pin_s1_reg && ctrl_wr
      && ctrl_cmd.external_pin_reset_cmd |=> nrst_pin_oe ##1 (nrst_pin_oe || $past(tick_reg)))
      else $error("pin not driven");
   oe_tick_a: assert property ($fell(nrst_pin_oe) |-> $past(tick_reg))
      else $error("pin drive ended off a slow tick");
   soft_len_a: assert property ($fell(busy_reg) && $past(tick_reg)
      |-> $past(soft_ticks_seen) >= 4'h2) else $error("soft reset too short");
   soft_rel_a: assert property ($fell(proc_reg) && $past(busy_reg)
      |-> $past(tick_reg) && $past(soft_ticks_seen) == 4'h2)
      else $error("soft release misaligned");
   user_entry_a: assert property (state_reg == ST_IDLE && user_reset_enable
      && !pin_s1_reg |=> proc_reset && periph_reset && !proc_clk_en)
      else $error("user reset not entered");
   user_cause_a: assert property ($fell(proc_reg) && $past(state_reg) == ST_USER_WAIT
      |-> reset_cause_field == CAUSE_USER) else $error("user cause not loaded");
endmodule

// File: test/srr_board.sv
// board model of the reset pin: open-drain line with pull-up and a push button
`timescale 1ns/1ns
module srr_board (
   input wire logic nrst_pin_out, // device drive value
   input wire logic nrst_pin_oe, // device drive enable
   input wire logic button_low, // push button held down
   output logic nrst_pin_in // resolved pin level
);
   // pull-up wins unless the device or the button pulls the line low
   assign nrst_pin_in = !((nrst_pin_oe && !nrst_pin_out) || button_low);
endmodule

// File: test/srr_tb.sv
// self-checking bench of the soft and user reset sequencer
`timescale 1ns/1ns
module testbench
   import srr_pkg::*;
;
   localparam int DIV = 8;
   typedef struct packed {
      logic [2:0] cmd;
      logic [2:0] cause;
   } srr_row_t;
   srr_row_t rows [8] = '{'{3'h0, 3'h0}, '{3'h2, 3'h0}, '{3'h4, 3'h0}, '{3'h6, 3'h0},
      '{3'h1, 3'h3}, '{3'h3, 3'h3}, '{3'h5, 3'h3}, '{3'h7, 3'h3}};
   logic clk = 0, rst = 1, ctrl_wr = 0, user_reset_enable = 0, button_low = 0;
   srr_cmd_t ctrl_cmd = '0;
   logic [ERST_LEN_W-1:0] external_reset_length = '0;
   logic nrst_pin_in, nrst_pin_out, nrst_pin_oe, proc_reset, periph_reset, proc_clk_en;
   logic soft_reset_in_progress;
   logic [2:0] reset_cause_field;
   int errors = 0, checks_done = 0, n;
   srr_ctrl #(.SLOW_DIV(DIV)) u_dut (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
      .ctrl_cmd(ctrl_cmd), .user_reset_enable(user_reset_enable),
      .external_reset_length(external_reset_length), .nrst_pin_in(nrst_pin_in),
      .nrst_pin_out(nrst_pin_out), .nrst_pin_oe(nrst_pin_oe), .proc_reset(proc_reset),
      .periph_reset(periph_reset), .proc_clk_en(proc_clk_en),
      .soft_reset_in_progress(soft_reset_in_progress), .reset_cause_field(reset_cause_field));
   srr_board u_board (.nrst_pin_out(nrst_pin_out), .nrst_pin_oe(nrst_pin_oe),
      .button_low(button_low), .nrst_pin_in(nrst_pin_in));
   // master clock, 10 ns period
   initial
   begin
      forever #5 clk = ~clk;
   end
   // verdict and end of run
   task close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one comparison
   task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask
   // one-cycle control write, checked two falling edges later
   task do_write(input logic [2:0] c);
      ctrl_wr = 1;
      ctrl_cmd = srr_cmd_t'(c);
      @(negedge clk);
      ctrl_wr = 0;
      ctrl_cmd = '0;
      @(negedge clk);
   endtask
   // count falling edges while a chosen output holds a level, bounded
   task run_len(input int sel, input logic val, output int cnt);
      logic s;
      cnt = 0;
      forever
      begin
         case (sel)
            0: s = soft_reset_in_progress;
            1: s = proc_reset;
            2: s = nrst_pin_oe;
            default: s = proc_clk_en;
         endcase
         if (s !== val)
            break;
         if (cnt == 400)
         begin
            $display("wrong value wait expected end seen timeout");
            errors++;
            close_out();
         end
         cnt++;
         @(negedge clk);
      end
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(negedge clk);
      rst = 0;
      chk("cause_after_reset", 4'h0, {1'b0, reset_cause_field});
      chk("clk_en_after_reset", 4'h1, {3'h0, proc_clk_en});
      // every command combination from the table
      foreach (rows[i])
      begin
         do_write(rows[i].cmd);
         chk("proc_reset", {3'h0, rows[i].cmd[0]}, {3'h0, proc_reset});
         chk("periph_reset", {3'h0, rows[i].cmd[1]}, {3'h0, periph_reset});
         chk("pin_oe", {3'h0, rows[i].cmd[2]}, {3'h0, nrst_pin_oe});
         chk("busy", {3'h0, rows[i].cmd != 3'h0}, {3'h0, soft_reset_in_progress});
         chk("cause", {1'b0, rows[i].cause}, {1'b0, reset_cause_field});
         run_len(0, 1'b1, n);
         if (rows[i].cmd != 3'h0 && !rows[i].cmd[2])
            chk("soft_len_ok", 4'h1, {3'h0, n >= 2 * DIV && n <= 3 * DIV - 1});
         chk("resets_released", 4'h0, {1'b0, proc_reset, periph_reset, nrst_pin_oe});
      end
      // writes while busy are dropped
      rst = 1;
      @(negedge clk);
      rst = 0;
      do_write(3'h2);
      do_write(3'h1);
      chk("proc_while_busy", 4'h0, {3'h0, proc_reset});
      chk("cause_while_busy", 4'h0, {1'b0, reset_cause_field});
      run_len(0, 1'b1, n);
      // long pin pulse with user reset enabled must not start a user reset
      user_reset_enable = 1;
      external_reset_length = 4'h3;
      do_write(3'h4);
      run_len(2, 1'b1, n);
      chk("pin_pulse_len_ok", 4'h1, {3'h0, n >= 3 * DIV && n <= 4 * DIV - 1});
      run_len(0, 1'b1, n);
      repeat (3 * DIV) @(negedge clk);
      chk("no_user_from_pulse", 4'h0, {proc_reset, reset_cause_field});
      // pin low with enable clear does nothing
      user_reset_enable = 0;
      button_low = 1;
      repeat (4 * DIV) @(negedge clk);
      chk("disabled_user", 4'h0, {1'b0, proc_reset, periph_reset, !proc_clk_en});
      // user reset entry and exit
      user_reset_enable = 1;
      run_len(1, 1'b0, n);
      chk("user_entry_fast", 4'h1, {3'h0, n <= 6 * DIV});
      @(negedge clk);
      chk("user_resets", 4'h6, {1'b0, proc_reset, periph_reset, proc_clk_en});
      repeat (4 * DIV) @(negedge clk);
      button_low = 0;
      run_len(3, 1'b0, n);
      chk("clk_en_back_ok", 4'h1, {3'h0, n >= DIV + 3 && n <= 2 * DIV + 2});
      chk("still_reset", 4'h1, {3'h0, proc_reset});
      run_len(1, 1'b1, n);
      chk("startup_len_ok", 4'h1, {3'h0, n == 3 * DIV});
      chk("cause_user", 4'h4, {1'b0, reset_cause_field});
      chk("periph_released", 4'h0, {3'h0, periph_reset});
      // held pin from idle: resync latency, reset held while low, then full exit
      button_low = 1;
      run_len(1, 1'b0, n);
      chk("user_sync_delay_ok", 4'h1, {3'h0, n >= 4 && n <= DIV + 3});
      repeat (3 * DIV) @(negedge clk);
      chk("user_held", 4'h2, {2'h0, proc_reset, proc_clk_en});
      button_low = 0;
      run_len(1, 1'b1, n);
      chk("user_exit_len_ok", 4'h1, {3'h0, n >= 4 * DIV + 3 && n <= 5 * DIV + 2});
      chk("cause_user_again", 4'h4, {1'b0, reset_cause_field});
      close_out();
   end
endmodule
